// ===== src/pei_pkg.sv
// package: register map, field layout and reset values of the phy event interrupt status register
package pei_pkg;
    localparam int          REG_W          = 16;
    localparam int          EVT_N          = 8;
    localparam logic [4:0]  ADDR_IRQ_CS    = 5'h11;
    localparam logic [15:0] RESET_IRQ_CS   = 16'h0000;
    localparam logic [7:0]  RESET_FLAGS    = 8'h00;
    localparam logic [7:0]  RESET_ENABLES  = 8'h00;
    localparam int          FLAG_LSB       = 0;
    localparam int          ENABLE_LSB     = 8;
    // event bit positions inside each byte
    localparam int          EVT_AUTONEG    = 0;
    localparam int          EVT_RFAULT     = 1;
    localparam int          EVT_LINKCHG    = 2;
    localparam int          EVT_PARTNERACK = 3;
    localparam int          EVT_PDFAULT    = 4;
    localparam int          EVT_PAGERX     = 5;
    localparam int          EVT_RXERR      = 6;
    localparam int          EVT_JABBER     = 7;
endpackage

// ===== src/pei_evt_if.sv
// interface: event flags and enables passed from the register core to the irq combiner
`timescale 1ns/1ps
interface pei_evt_if #(parameter int EVT_N = 8);
    logic [EVT_N-1:0] flags;
    logic [EVT_N-1:0] enables;
    logic             irq;
    modport core (output flags, output enables, input irq);
    modport comb (input flags, input enables, output irq);
endinterface

// ===== src/pei_irq_comb.sv
// module: combines latched event flags with their enables into one irq request
`timescale 1ns/1ps
module pei_irq_comb #(
    parameter int EVT_N = 8
) (
    pei_evt_if.comb bus
);
    logic [EVT_N-1:0] gated;

    genvar g;
    generate
        for (g = 0; g < EVT_N; g++) begin : g_gate
            assign gated[g] = bus.flags[g] & bus.enables[g];
        end
    endgenerate

    assign bus.irq = |gated;
endmodule

// ===== src/pei_top.sv
// module: phy event interrupt control and status register with clear-on-read flags
`timescale 1ns/1ps
module pei_top #(
    parameter int EVT_N = pei_pkg::EVT_N
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [EVT_N-1:0] i_evt,
    input  wire logic [4:0]       i_mgmt_addr,
    input  wire logic             i_mgmt_rd,
    input  wire logic             i_mgmt_wr,
    input  wire logic [15:0]      i_mgmt_wdata,
    output logic [15:0]           o_mgmt_rdata,
    output logic                  o_mac_raw_irq_status
);
    // synchroniser and edge detect
    logic [EVT_N-1:0] evt_s1;
    logic [EVT_N-1:0] evt_s2;
    logic [EVT_N-1:0] evt_d;
    logic [EVT_N-1:0] evt_rise;
    // register state and read path
    logic [EVT_N-1:0] flags;
    logic [EVT_N-1:0] enables;
    logic [EVT_N-1:0] rd_flags;
    logic [EVT_N-1:0] rd_enables;
    logic [15:0]      rd_word;
    logic             sel;
    logic             rd_hit;
    logic             wr_hit;

    // flag views, one per event, in register bit order
    logic             jabber_event_flag;
    logic             rx_error_event_flag;
    logic             page_received_flag;
    logic             parallel_detect_fault_flag;
    logic             partner_ack_flag;
    logic             link_change_flag;
    logic             remote_fault_flag;
    logic             autoneg_done_flag;

    // enable views, one per event, in register bit order
    logic             jabber_event_enable;
    logic             rx_error_event_enable;
    logic             page_received_enable;
    logic             parallel_detect_fault_enable;
    logic             partner_ack_enable;
    logic             link_change_enable;
    logic             remote_fault_enable;
    logic             autoneg_done_enable;

    // byte lanes of the register word
    localparam int FLAG_LO   = pei_pkg::FLAG_LSB;
    localparam int ENABLE_LO = pei_pkg::ENABLE_LSB;

    // flags and enables travel to the combiner together
    pei_evt_if #(.EVT_N(EVT_N)) evt_bus ();

    // event sources come from other logic domains inside the phy; each level passes
    // two flops before anything else looks at it
    genvar b;
    generate
        for (b = 0; b < EVT_N; b++) begin : g_sync
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    evt_s1[b] <= 1'b0;
                end else begin
                    evt_s1[b] <= i_evt[b];
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    evt_s2[b] <= 1'b0;
                end else begin
                    evt_s2[b] <= evt_s1[b];
                end
            end
        end
    endgenerate

    // the delayed copy resets to the idle low level, so a line that is low at reset
    // gives no false edge; a line already high at release counts as one event
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            evt_d <= '0;
        end else begin
            evt_d <= evt_s2;
        end
    end

    // an event counts once per occurrence: rising edge of the level
    assign evt_rise = evt_s2 & ~evt_d;

    // only one address belongs to this block; other registers are decoded elsewhere
    // a read and a write in the same cycle both act
    always_comb begin
        sel = 1'b0;
        if (i_mgmt_addr == pei_pkg::ADDR_IRQ_CS) begin
            sel = 1'b1;
        end
        rd_hit = sel & i_mgmt_rd;
        wr_hit = sel & i_mgmt_wr;
    end

    // clear-on-read: every read of ADDR_IRQ_CS consumes the events it reports, so a polling station
    // sees each occurrence once; an event in the read cycle itself survives the clear
    generate
        for (b = 0; b < EVT_N; b++) begin : g_flag
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    flags[b] <= pei_pkg::RESET_FLAGS[b];
                end else if (evt_rise[b]) begin
                    flags[b] <= 1'b1;
                end else if (rd_hit) begin
                    flags[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // the low byte of a write is dropped: flags are cleared only by reading or by reset
    generate
        for (b = 0; b < EVT_N; b++) begin : g_enable
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    enables[b] <= pei_pkg::RESET_ENABLES[b];
                end else if (wr_hit) begin
                    enables[b] <= i_mgmt_wdata[ENABLE_LO + b];
                end
            end
        end
    endgenerate

    // named views keep the bit layout in one place
    assign autoneg_done_flag          = flags[pei_pkg::EVT_AUTONEG];
    assign remote_fault_flag          = flags[pei_pkg::EVT_RFAULT];
    assign link_change_flag           = flags[pei_pkg::EVT_LINKCHG];
    assign partner_ack_flag           = flags[pei_pkg::EVT_PARTNERACK];
    assign parallel_detect_fault_flag = flags[pei_pkg::EVT_PDFAULT];
    assign page_received_flag         = flags[pei_pkg::EVT_PAGERX];
    assign rx_error_event_flag        = flags[pei_pkg::EVT_RXERR];
    assign jabber_event_flag          = flags[pei_pkg::EVT_JABBER];

    assign autoneg_done_enable          = enables[pei_pkg::EVT_AUTONEG];
    assign remote_fault_enable          = enables[pei_pkg::EVT_RFAULT];
    assign link_change_enable           = enables[pei_pkg::EVT_LINKCHG];
    assign partner_ack_enable           = enables[pei_pkg::EVT_PARTNERACK];
    assign parallel_detect_fault_enable = enables[pei_pkg::EVT_PDFAULT];
    assign page_received_enable         = enables[pei_pkg::EVT_PAGERX];
    assign rx_error_event_enable        = enables[pei_pkg::EVT_RXERR];
    assign jabber_event_enable          = enables[pei_pkg::EVT_JABBER];

    // read bytes rebuilt from the named views, most significant event first
    assign rd_flags = {
        jabber_event_flag,
        rx_error_event_flag,
        page_received_flag,
        parallel_detect_fault_flag,
        partner_ack_flag,
        link_change_flag,
        remote_fault_flag,
        autoneg_done_flag
    };

    assign rd_enables = {
        jabber_event_enable,
        rx_error_event_enable,
        page_received_enable,
        parallel_detect_fault_enable,
        partner_ack_enable,
        link_change_enable,
        remote_fault_enable,
        autoneg_done_enable
    };

    // lanes not covered by an event keep the reset pattern
    always_comb begin
        rd_word                     = pei_pkg::RESET_IRQ_CS;
        rd_word[FLAG_LO +: EVT_N]   = rd_flags;
        rd_word[ENABLE_LO +: EVT_N] = rd_enables;
    end

    // read data is registered and shows the flags from before the clear; a read of any
    // other address returns zero so a stale word cannot pass for this register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mgmt_rdata <= pei_pkg::RESET_IRQ_CS;
        end else if (rd_hit) begin
            o_mgmt_rdata <= rd_word;
        end else if (i_mgmt_rd) begin
            o_mgmt_rdata <= pei_pkg::RESET_IRQ_CS;
        end
    end

    assign evt_bus.flags   = flags;
    assign evt_bus.enables = enables;

    pei_irq_comb #(.EVT_N(EVT_N)) u_comb (
        .bus (evt_bus)
    );

    // registered so the status line to the mac cannot glitch while a flag and its
    // enable change in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mac_raw_irq_status <= 1'b0;
        end else begin
            o_mac_raw_irq_status <= evt_bus.irq;
        end
    end
endmodule

// ===== verif/pei_top_assertions.sv
// checker: port-level assertions for the event interrupt register
`timescale 1ns/1ps
module pei_chk #(
    parameter int EVT_N = pei_pkg::EVT_N
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [EVT_N-1:0] i_evt,
    input  wire logic [4:0]       i_mgmt_addr,
    input  wire logic             i_mgmt_rd,
    input  wire logic             i_mgmt_wr,
    input  wire logic [15:0]      i_mgmt_wdata,
    input  wire logic [15:0]      o_mgmt_rdata,
    input  wire logic             o_mac_raw_irq_status
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    wire logic [15:0] q = o_mgmt_rdata;
    wire logic        r = i_mgmt_rd && (i_mgmt_addr == pei_pkg::ADDR_IRQ_CS);
    a_rst_zero: assert property ($past(i_rst) |-> !q && !o_mac_raw_irq_status) else $error("rst");
    a_other_zero: assert property (i_mgmt_rd && !r |=> !q) else $error("adr");
    a_data_hold: assert property (!i_mgmt_rd |=> $stable(q)) else $error("hld");
    a_irq_or: assert property ($past(r) |-> o_mac_raw_irq_status == |(q[15:8] & q[7:0])) else $error("or");
    a_jabber_irq: assert property ($past(r) && q[15] && q[7] |-> o_mac_raw_irq_status) else $error("jab");
    a_evt_set: assert property ($rose(i_evt[0]) ##1 !i_mgmt_rd [*3] ##1 r |=> q[0]) else $error("set");
    a_read_clear: assert property ($stable(i_evt) [*5] ##0 r ##1 !i_mgmt_rd && $stable(i_evt)
        ##1 r && $stable(i_evt) |=> !q[7:0]) else $error("clr");
    a_en_back: assert property (i_mgmt_wr && i_mgmt_addr == pei_pkg::ADDR_IRQ_CS ##1 !i_mgmt_wr ##1 r
        |=> q[15:8] == $past(i_mgmt_wdata[15:8], 3)) else $error("en");
    cover property (r ##1 o_mac_raw_irq_status);
    cover property (i_mgmt_wr);
    cover property (i_mgmt_rd && !r);
endmodule
bind pei_top pei_chk #(.EVT_N(EVT_N)) u_pei_chk (.*);

// ===== verif/pei_sta.sv
// model: management station issuing one-cycle register accesses
`timescale 1ns/1ps
module pei_sta (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_rdata,
    output logic [4:0]       o_a = 5'h00,
    output logic             o_rd = 1'b0,
    output logic             o_wr = 1'b0,
    output logic [15:0]      o_d = 16'h0000
);
    task automatic io(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge i_mclk) {o_a, o_rd, o_wr, o_d} <= {a, !w, w, d};
        @(negedge i_mclk) q = i_rdata;
        // released lines flip so a stale word never passes for a live one
        {o_a, o_rd, o_wr, o_d} <= {~a, 2'b00, ~d};
    endtask
endmodule

// ===== verif/tb.sv
// testbench: event, mask, clear-on-read and decode scenarios
`timescale 1ns/1ps
module tb;
    logic        i_mclk = 0, i_rst = 1, i_mgmt_rd, i_mgmt_wr, o_mac_raw_irq_status;
    logic [7:0]  i_evt = 8'h00;
    logic [4:0]  i_mgmt_addr;
    logic [15:0] i_mgmt_wdata, o_mgmt_rdata, v;
    int          n_errors = 0, checks = 0, cyc = 0;
    always #50 i_mclk = ~i_mclk;
    pei_top u_pei_top (.*);
    pei_sta u_pei_sta (.i_mclk(i_mclk), .i_rdata(o_mgmt_rdata), .o_a(i_mgmt_addr), .o_rd(i_mgmt_rd),
        .o_wr(i_mgmt_wr), .o_d(i_mgmt_wdata));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_events();
        u_pei_sta.io(1, 5'h11, 16'hffa5, v);
        i_evt = 8'h81; repeat (3) @(negedge i_mclk);
        u_pei_sta.io(0, 5'h11, 16'h0000, v); chk(v, 16'hff81);
        chk(16'(o_mac_raw_irq_status), 16'h0001);
        repeat (2) u_pei_sta.io(0, 5'h11, 16'h0000, v);
        chk(v, 16'hff00);
        chk(16'(o_mac_raw_irq_status), 16'h0000);
    endtask
    task automatic t_mask();
        u_pei_sta.io(1, 5'h11, 16'h40ff, v);
        u_pei_sta.io(0, 5'h11, 16'h0000, v); chk(v, 16'h4000);
        i_evt = 8'h10; repeat (6) @(negedge i_mclk);
        chk(16'(o_mac_raw_irq_status), 16'h0000);
        u_pei_sta.io(0, 5'h10, 16'h0000, v); chk(v, 16'h0000);
        u_pei_sta.io(1, 5'h11, 16'h1000, v);
        u_pei_sta.io(1, 5'h12, 16'h4000, v);
        @(negedge i_mclk);
        chk(16'(o_mac_raw_irq_status), 16'h0001);
        u_pei_sta.io(0, 5'h11, 16'h0000, v);
        chk(v, 16'h1010);
    endtask
    task automatic t_reset();
        i_evt = 8'h20;
        repeat (4) @(negedge i_mclk);
        i_evt = 8'h00;
        i_rst = 1;
        repeat (2) @(negedge i_mclk);
        i_rst = 0;
        u_pei_sta.io(0, 5'h11, 16'h0000, v);
        chk(v, 16'h0000);
        chk(16'(o_mac_raw_irq_status), 16'h0000);
    endtask
    always @(posedge i_mclk) if (++cyc == 300) begin n_errors++; report_and_stop(); end
    initial begin
        repeat (6) @(negedge i_mclk);
        i_rst = 0; t_events(); t_mask(); t_reset(); report_and_stop();
    end
endmodule
